// ### hw/acv_trim_volume_regs.sv
// Channel 2 trim/skew and channel 3 routing/volume register bank
//
// Summary of operation
// - Channel 2 fine trim bits 7-4, 0.1 dB steps
// - Fine trim resets to code 8, 0 dB
// - Channel 2 skew delay bits 7-2, 0..63
// - Bit 7 routes channel 1 input to 3
// - Channel 3 volume code zero fully mutes
// - Volume 0.5 dB steps, 161 is 0 dB
`timescale 1ns/1ns
`default_nettype none
module acv_trim_volume_regs
   import acv_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              REF_CLK_IN,
   input  wire logic              RST_B_IN,
   // Control port register access
   input  wire logic [ADDR_W-1:0] REG_ADDR_IN,
   input  wire logic              REG_WR_EN_IN,
   input  wire logic [7:0]        REG_WDATA_IN,
   input  wire logic              REG_RD_EN_IN,
   output logic [7:0]             REG_RDATA_OUT,
   output logic                   REG_RD_VALID_OUT,
   // Settings to the channel datapath
   output acv_cfg_s               CFG_OUT
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration check

   // Offsets up to 0x5B need at least seven address bits
   generate
      if (ADDR_W < 7 || ADDR_W > 16) begin : g_bad_addr
         $error("ADDR_W must be 7 to 16");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Register storage

   logic [7:0]          reg_val [NUM_REGS];
   logic [NUM_REGS-1:0] hit;

   // One register per entry, reserved bits forced to reset value
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         assign hit[gi] = (REG_ADDR_IN == ADDR_W'(REG_OFS[gi]));
         acv_field_reg #(
            .RESET_VAL (REG_RST[gi]),
            .WMASK     (REG_WMASK[gi])
         ) u_reg (
            .clk_in    (REF_CLK_IN),
            .rst_b_in  (RST_B_IN),
            .wr_en_in  (REG_WR_EN_IN && hit[gi]),
            .wdata_in  (REG_WDATA_IN),
            .value_out (reg_val[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read path

   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       rvalid_reg;
   logic       rvalid_next;

   // Select addressed register; unmapped addresses read zero
   always_comb begin
      rdata_next  = 8'h00;
      rvalid_next = REG_RD_EN_IN;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (REG_RD_EN_IN && hit[i]) begin
            rdata_next = reg_val[i];
         end
      end
   end

   // Registered read answer
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign REG_RDATA_OUT    = rdata_reg;
   assign REG_RD_VALID_OUT = rvalid_reg;

   ////////////////////////////////////////////////////////////////////////
   // Settings decode

   acv_cfg_s cfg_reg;
   acv_cfg_s cfg_next;

   // Decode fields into gains, routing and mute
   always_comb begin
      cfg_next = '0;
      cfg_next.ch2_fine_trim =
         reg_val[IDX_FINE][FINE_TRIM_MSB:FINE_TRIM_LSB];
      cfg_next.ch2_trim_tenth_db =
         $signed({1'b0, cfg_next.ch2_fine_trim})
         - FINE_TRIM_ZERO_CODE;
      cfg_next.ch2_skew_delay =
         reg_val[IDX_SKEW][SKEW_MSB:SKEW_LSB];
      cfg_next.ch3_copy_from_ch1 = reg_val[IDX_SRC][COPY_BIT];
      cfg_next.ch3_volume_level  = reg_val[IDX_VOL];
      cfg_next.ch3_mute =
         (reg_val[IDX_VOL] == VOL_MUTE_CODE);
      if (!cfg_next.ch3_mute) begin
         cfg_next.ch3_vol_half_db =
            $signed({1'b0, reg_val[IDX_VOL]}) - VOL_ZERO_CODE;
      end
   end

   // Settings change whole, one cycle after the register write
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         cfg_reg                   <= '0;
         cfg_reg.ch2_fine_trim     <= CH2_FINE_GAIN_CFG_RST[7:4];
         cfg_reg.ch2_trim_tenth_db <= 5'sh00;
         cfg_reg.ch3_volume_level  <= CH3_VOLUME_CFG_RST;
         cfg_reg.ch3_vol_half_db   <= 9'sh000;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   assign CFG_OUT = cfg_reg;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   a_trim_gain_map : assert property (
      CFG_OUT.ch2_trim_tenth_db ==
      $signed({1'b0, CFG_OUT.ch2_fine_trim}) - 5'sh08)
      else $error("fine trim gain does not match code");

   a_trim_reset_zero : assert property (
      $rose(RST_B_IN) |-> CFG_OUT.ch2_fine_trim == 4'h8
                          && CFG_OUT.ch2_trim_tenth_db == 5'sh00)
      else $error("fine trim not 0 dB after reset");

   a_skew_write : assert property (
      REG_WR_EN_IN && REG_ADDR_IN == ADDR_W'(8'h59)
      |-> ##2 CFG_OUT.ch2_skew_delay == $past(REG_WDATA_IN[7:2], 2))
      else $error("skew delay did not follow write");

   a_copy_route : assert property (
      REG_WR_EN_IN && REG_ADDR_IN == ADDR_W'(8'h5A)
      |-> ##2 CFG_OUT.ch3_copy_from_ch1 == $past(REG_WDATA_IN[7], 2))
      else $error("channel 3 routing did not follow write");

   a_vol_mute : assert property (
      CFG_OUT.ch3_mute == (CFG_OUT.ch3_volume_level == 8'h00))
      else $error("mute does not match volume code zero");

   a_vol_gain : assert property (
      !CFG_OUT.ch3_mute |-> CFG_OUT.ch3_vol_half_db ==
      $signed({1'b0, CFG_OUT.ch3_volume_level}) - 9'sh0A1)
      else $error("volume gain does not match code");

   a_rsvd_zero : assert property (
      REG_RD_EN_IN && REG_ADDR_IN == ADDR_W'(8'h59)
      |=> REG_RD_VALID_OUT && REG_RDATA_OUT[1:0] == 2'b00)
      else $error("reserved skew bits read nonzero");

   a_field_keep : assert property (
      REG_WR_EN_IN && REG_ADDR_IN == ADDR_W'(8'h58)
      |-> ##2 $stable(CFG_OUT.ch2_skew_delay)
              && $stable(CFG_OUT.ch3_volume_level))
      else $error("trim write disturbed other fields");

   a_trim_write : assert property (
      REG_WR_EN_IN && REG_ADDR_IN == ADDR_W'(CH2_FINE_GAIN_CFG_OFS)
      |-> ##2 CFG_OUT.ch2_fine_trim == $past(REG_WDATA_IN[7:4], 2))
      else $error("fine trim did not follow write");

   a_trim_low_end : assert property (
      CFG_OUT.ch2_fine_trim == 4'h0
      |-> CFG_OUT.ch2_trim_tenth_db == -5'sh08)
      else $error("trim code 0 is not -0.8 dB");

   a_trim_high_end : assert property (
      CFG_OUT.ch2_fine_trim == 4'hF
      |-> CFG_OUT.ch2_trim_tenth_db == 5'sh07)
      else $error("trim code 15 is not +0.7 dB");

   a_vol_write : assert property (
      REG_WR_EN_IN && REG_ADDR_IN == ADDR_W'(CH3_VOLUME_CFG_OFS)
      |-> ##2 CFG_OUT.ch3_volume_level == $past(REG_WDATA_IN, 2))
      else $error("volume did not follow write");

   a_vol_low_end : assert property (
      CFG_OUT.ch3_volume_level == 8'h01
      |-> CFG_OUT.ch3_vol_half_db == -9'sh0A0)
      else $error("volume code 1 is not -80 dB");

   a_vol_high_end : assert property (
      CFG_OUT.ch3_volume_level == 8'hFF
      |-> CFG_OUT.ch3_vol_half_db == 9'sh05E)
      else $error("volume code 255 is not +47 dB");

   a_vol_reset : assert property (
      $rose(RST_B_IN) |-> CFG_OUT.ch3_volume_level == CH3_VOLUME_CFG_RST
                          && CFG_OUT.ch3_vol_half_db == 9'sh000)
      else $error("volume not 0 dB after reset");

   a_rsvd_trim : assert property (
      REG_RD_EN_IN && REG_ADDR_IN == ADDR_W'(CH2_FINE_GAIN_CFG_OFS)
      |=> REG_RD_VALID_OUT && REG_RDATA_OUT[3:0] == 4'h0)
      else $error("reserved trim bits read nonzero");

   a_rsvd_src : assert property (
      REG_RD_EN_IN && REG_ADDR_IN == ADDR_W'(CH3_INPUT_SOURCE_CFG_OFS)
      |=> REG_RD_VALID_OUT && REG_RDATA_OUT[6:0] == 7'h00)
      else $error("reserved routing bits read nonzero");

endmodule : acv_trim_volume_regs
`default_nettype wire

// ### hw/acv_pkg.sv
// Package for the channel trim and volume register bank
package acv_pkg;

   // Register count and byte width
   localparam int          NUM_REGS       = 4;
   localparam int          DATA_W         = 8;

   // Register offsets on the control port
   localparam logic [7:0]  CH2_FINE_GAIN_CFG_OFS    = 8'h58;
   localparam logic [7:0]  CH2_PHASE_DELAY_CFG_OFS  = 8'h59;
   localparam logic [7:0]  CH3_INPUT_SOURCE_CFG_OFS = 8'h5A;
   localparam logic [7:0]  CH3_VOLUME_CFG_OFS       = 8'h5B;

   // Reset values
   localparam logic [7:0]  CH2_FINE_GAIN_CFG_RST    = 8'h80;
   localparam logic [7:0]  CH2_PHASE_DELAY_CFG_RST  = 8'h00;
   localparam logic [7:0]  CH3_INPUT_SOURCE_CFG_RST = 8'h00;
   localparam logic [7:0]  CH3_VOLUME_CFG_RST       = 8'hA1;

   // Writable bit masks; cleared bits are reserved, read-only zero
   localparam logic [7:0]  CH2_FINE_GAIN_CFG_WMASK    = 8'hF0;
   localparam logic [7:0]  CH2_PHASE_DELAY_CFG_WMASK  = 8'hFC;
   localparam logic [7:0]  CH3_INPUT_SOURCE_CFG_WMASK = 8'h80;
   localparam logic [7:0]  CH3_VOLUME_CFG_WMASK       = 8'hFF;

   // Tables indexed by register number
   localparam logic [7:0] REG_OFS [NUM_REGS] = '{
      CH2_FINE_GAIN_CFG_OFS, CH2_PHASE_DELAY_CFG_OFS,
      CH3_INPUT_SOURCE_CFG_OFS, CH3_VOLUME_CFG_OFS};
   localparam logic [7:0] REG_RST [NUM_REGS] = '{
      CH2_FINE_GAIN_CFG_RST, CH2_PHASE_DELAY_CFG_RST,
      CH3_INPUT_SOURCE_CFG_RST, CH3_VOLUME_CFG_RST};
   localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
      CH2_FINE_GAIN_CFG_WMASK, CH2_PHASE_DELAY_CFG_WMASK,
      CH3_INPUT_SOURCE_CFG_WMASK, CH3_VOLUME_CFG_WMASK};

   // Register numbers
   localparam int          IDX_FINE       = 0;
   localparam int          IDX_SKEW       = 1;
   localparam int          IDX_SRC        = 2;
   localparam int          IDX_VOL        = 3;

   // Field positions
   localparam int          FINE_TRIM_MSB  = 7;
   localparam int          FINE_TRIM_LSB  = 4;
   localparam int          SKEW_MSB       = 7;
   localparam int          SKEW_LSB       = 2;
   localparam int          COPY_BIT       = 7;

   // Trim code giving 0 dB, volume code giving 0 dB, mute code
   localparam logic signed [4:0] FINE_TRIM_ZERO_CODE = 5'sh08;
   localparam logic signed [8:0] VOL_ZERO_CODE       = 9'sh0A1;
   localparam logic [7:0]        VOL_MUTE_CODE       = 8'h00;

   // Settings handed to the channel datapath
   typedef struct packed {
      logic [3:0]         ch2_fine_trim;      // Code, 0.1 dB steps
      logic signed [4:0]  ch2_trim_tenth_db;  // Gain in 0.1 dB units
      logic [5:0]         ch2_skew_delay;     // Modulator cycles
      logic               ch3_copy_from_ch1;  // Take ch1 filter input
      logic [7:0]         ch3_volume_level;   // Volume code
      logic               ch3_mute;           // Code zero mutes
      logic signed [8:0]  ch3_vol_half_db;    // Gain in 0.5 dB units
   } acv_cfg_s;

endpackage : acv_pkg

// ### hw/acv_field_reg.sv
// One byte-wide configuration register with a writable-bit mask
`timescale 1ns/1ns
`default_nettype none
module acv_field_reg #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WMASK     = 8'hFF
) (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   // Write side
   input  wire logic       wr_en_in,
   input  wire logic [7:0] wdata_in,
   // Stored value
   output logic [7:0]      value_out
);

   logic [7:0] value_reg;
   logic [7:0] value_next;

   // Merge written bits; reserved bits keep their reset value
   always_comb begin
      value_next = value_reg;
      if (wr_en_in) begin
         value_next = (wdata_in & WMASK) | (RESET_VAL & ~WMASK);
      end
   end

   // Storage
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         value_reg <= RESET_VAL;
      end else begin
         value_reg <= value_next;
      end
   end

   assign value_out = value_reg;

endmodule : acv_field_reg
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the trim and volume register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import acv_pkg::*;
;

   typedef struct {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
   } acv_row_s;

   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic       wr_en = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic       rd_en = 1'b0;
   logic [7:0] rdata;
   logic       rd_valid;
   acv_cfg_s   cfg;
   logic [7:0] mdl [NUM_REGS];
   int         miscompares = 0;
   int         tests_run = 0;
   int         cycles = 0;
   acv_row_s   rows [11] = '{
      '{8'h58, 8'hFF, 8'hF0}, '{8'h58, 8'h00, 8'h00}, '{8'h59, 8'hFF, 8'hFC},
      '{8'h59, 8'h04, 8'h04}, '{8'h5A, 8'hFF, 8'h80}, '{8'h5A, 8'h7F, 8'h00},
      '{8'h5B, 8'h00, 8'h00}, '{8'h5B, 8'h01, 8'h01}, '{8'h5B, 8'hFF, 8'hFF},
      '{8'h5B, 8'hA1, 8'hA1}, '{8'h3C, 8'h55, 8'h00}};

   acv_trim_volume_regs #(.ADDR_W(8)) u_dut (
      .REF_CLK_IN      (clk),
      .RST_B_IN        (rst_b),
      .REG_ADDR_IN     (addr),
      .REG_WR_EN_IN    (wr_en),
      .REG_WDATA_IN    (wdata),
      .REG_RD_EN_IN    (rd_en),
      .REG_RDATA_OUT   (rdata),
      .REG_RD_VALID_OUT(rd_valid),
      .CFG_OUT         (cfg)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare, verdict and bus tasks
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // Keep the model in step with a write that lands
   task automatic mdl_wr(input logic [7:0] a, input logic [7:0] d);
      for (int i = 0; i < NUM_REGS; i++) begin
         if (REG_OFS[i] === a) begin
            mdl[i] = (d & REG_WMASK[i]) | (REG_RST[i] & ~REG_WMASK[i]);
         end
      end
   endtask : mdl_wr

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr  = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
      mdl_wr(a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr  = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      check("rd_valid", rd_valid, 1'b1);
      check("rdata", rdata, exp);
   endtask : rd

   // Expected settings worked out from the model registers
   function automatic acv_cfg_s exp_cfg();
      acv_cfg_s c;
      c.ch2_fine_trim     = mdl[IDX_FINE][7:4];
      c.ch2_trim_tenth_db = $signed({1'b0, mdl[IDX_FINE][7:4]}) - 5'sh08;
      c.ch2_skew_delay    = mdl[IDX_SKEW][7:2];
      c.ch3_copy_from_ch1 = mdl[IDX_SRC][7];
      c.ch3_volume_level  = mdl[IDX_VOL];
      c.ch3_mute          = (mdl[IDX_VOL] == 8'h00);
      c.ch3_vol_half_db   = c.ch3_mute ? 9'sh000 :
                            $signed({1'b0, mdl[IDX_VOL]}) - 9'sh0A1;
      return c;
   endfunction : exp_cfg

   task automatic reset_defaults();
      for (int i = 0; i < NUM_REGS; i++) mdl[i] = REG_RST[i];
      check("cfg reset", cfg, exp_cfg());
      for (int i = 0; i < NUM_REGS; i++) begin
         rd(REG_OFS[i], REG_RST[i]);
      end
      @(negedge clk);
      check("valid drop", rd_valid, 1'b0);
      check("rdata drop", rdata, 8'h00);
   endtask : reset_defaults

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      reset_defaults();
      $display("test reset done");
      // Table rows: write, settle, compare settings and read back
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         @(negedge clk);
         check("cfg row", cfg, exp_cfg());
         rd(rows[i].addr, rows[i].rdata);
      end
      $display("test rows done");
      // Rule end points: trim, skew, routing, volume and mute
      wr(CH2_FINE_GAIN_CFG_OFS, 8'h00);
      wr(CH2_PHASE_DELAY_CFG_OFS, 8'hFC);
      wr(CH3_INPUT_SOURCE_CFG_OFS, 8'h80);
      wr(CH3_VOLUME_CFG_OFS, 8'h01);
      @(negedge clk);
      check("trim -0.8", $unsigned(cfg.ch2_trim_tenth_db), 5'h18);
      check("skew 63", cfg.ch2_skew_delay, 6'h3F);
      check("copy on", cfg.ch3_copy_from_ch1, 1'b1);
      check("vol -80", $unsigned(cfg.ch3_vol_half_db), 9'h160);
      wr(CH2_FINE_GAIN_CFG_OFS, 8'hF0);
      wr(CH3_VOLUME_CFG_OFS, 8'hFF);
      @(negedge clk);
      check("trim +0.7", $unsigned(cfg.ch2_trim_tenth_db), 5'h07);
      check("vol +47", $unsigned(cfg.ch3_vol_half_db), 9'h05E);
      wr(CH3_VOLUME_CFG_OFS, 8'h00);
      @(negedge clk);
      check("mute", cfg.ch3_mute, 1'b1);
      check("mute level", cfg.ch3_volume_level, 8'h00);
      $display("test end points done");
      // Back-to-back writes on consecutive cycles
      @(negedge clk);
      addr  = 8'h58;
      wdata = 8'h3C;
      wr_en = 1'b1;
      @(negedge clk);
      addr  = 8'h59;
      wdata = 8'h0B;
      @(negedge clk);
      wr_en = 1'b0;
      mdl_wr(8'h58, 8'h3C);
      mdl_wr(8'h59, 8'h0B);
      @(negedge clk);
      check("cfg b2b", cfg, exp_cfg());
      // Read and write together show the old value
      @(negedge clk);
      addr  = 8'h5B;
      wdata = 8'h22;
      wr_en = 1'b1;
      rd_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
      rd_en = 1'b0;
      check("rdata old", rdata, mdl[IDX_VOL]);
      mdl_wr(8'h5B, 8'h22);
      rd(8'h5B, 8'h22);
      $display("test back to back done");
      // Second reset in mid-run restores the defaults
      @(negedge clk);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      reset_defaults();
      $display("test second reset done");
      end_sim();
   end

endmodule : tb_top
`default_nettype wire
